// [rtl/nah_pkg.sv]
// nah_pkg: constants for the nand identification / address host controller
// assumes 125 MHz clk_sys; strobe and array-load counts derive from it, RB_SETTLE_CYC is a fixed cycle count
package nah_pkg;
    // =====================================================
    // clock and timing
    localparam int CLK_MHZ = 125;
    localparam int STROBE_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int ARRAY_LOAD_TIME_US = 55;
    localparam int ARRAY_LOAD_CYC = ARRAY_LOAD_TIME_US * CLK_MHZ;
    localparam int RB_SETTLE_CYC = 8;
    // =====================================================
    // nand command bytes, zero address byte and status ready mask
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_PARAM_PAGE = 8'hec;
    localparam logic [7:0] CMD_DUMMY_READ = 8'h00;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] ADDR_ZERO = 8'h00;
    localparam logic [7:0] STATUS_READY_BIT = 8'h40;
    // =====================================================
    // address layout
    localparam int COL_W = 13;
    localparam int PAGE_W = 6;
    localparam int BLOCK_W = 13;
    localparam int ADDR_CYCLES = 5;
    // =====================================================
    // avalon register map (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_COLUMN = 4'h4;
    localparam logic [3:0] REG_ROW = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    localparam int CTRL_GO = 0;
    localparam int CTRL_OP_LO = 1;
    localparam int CTRL_CE_SEL = 4;
    localparam int CTRL_USE_POLL = 5;
    localparam int CTRL_COUNT_LO = 8;
    // =====================================================
    // operations
    typedef enum logic [1:0] {
        NAH_OP_ID = 2'b00,
        NAH_OP_PARAM = 2'b01,
        NAH_OP_ADDR = 2'b10,
        NAH_OP_STATUS = 2'b11
    } nah_op_t;
endpackage

// [rtl/nah_pin_sync.sv]
// nah_pin_sync: three flip-flop synchroniser for an asynchronous pin
// assumes a level input; output changes once stages two and three agree
`timescale 1ns/1ps
module nah_pin_sync (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    // =====================================================
    // capture chain; s1 feeds only s2
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            level <= 1'b1;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end
endmodule

// [rtl/nah_host.sv]
// nah_host: host-side controller for a dual-die nand, identification and address front end
// assumes nand pins wired directly; software talks through avalon-mm with waitrequest
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
module nah_host
    import nah_pkg::*;
#(
    parameter int LOAD_CYC = ARRAY_LOAD_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic io_oe,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic re_n,
    output logic [1:0] ce_n,
    input wire logic ready_busy_n
);
    typedef enum logic [3:0] {
        NAH_IDLE = 4'b0000,
        NAH_CMD = 4'b0001,
        NAH_ADDR = 4'b0010,
        NAH_WAIT = 4'b0011,
        NAH_POLL_CMD = 4'b0100,
        NAH_POLL_RD = 4'b0101,
        NAH_REARM = 4'b0110,
        NAH_READ = 4'b0111,
        NAH_DONE = 4'b1000
    } nah_state_t;

    nah_state_t state;
    logic [31:0] ctrl;
    logic [COL_W-1:0] column;
    logic [PAGE_W+BLOCK_W-1:0] row;
    logic [31:0] id_lo;
    logic [7:0] id_hi;
    logic [7:0] last_byte;
    logic busy;
    logic after_id;
    logic [2:0] phase;
    logic [2:0] addr_idx;
    logic [7:0] rd_count;
    logic [31:0] timer;
    logic [7:0] addr_byte;
    logic rb_level;
    logic [7:0] io_level;
    nah_op_t op;

    nah_pin_sync u_rb (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin(ready_busy_n),
        .level(rb_level)
    );

    // data bus is asynchronous too; each bit settles after four cycles, one cycle inside the five-cycle read strobe
    for (genvar b = 0; b < 8; b++) begin : g_io_sync
        nah_pin_sync u_io (
            .clk_sys(clk_sys),
            .reset(reset),
            .pin(io_in[b]),
            .level(io_level[b])
        );
    end

    assign op = nah_op_t'(ctrl[CTRL_OP_LO +: 2]);

    // =====================================================
    // address byte mux
    always_comb begin
        addr_byte = ADDR_ZERO;
        if (op == NAH_OP_ADDR) begin
            unique case (addr_idx)
                3'd0: addr_byte = column[7:0];
                3'd1: addr_byte = {4'b0000, column[11:8]};
                3'd2: addr_byte = row[7:0];
                3'd3: addr_byte = row[15:8];
                default: addr_byte = {5'b00000, row[18:16]};
            endcase
        end
    end

    // =====================================================
    // avalon slave: registered waitrequest idles high, drops one cycle to accept
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || (avs_write && !busy)) && avs_waitrequest);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            unique case (avs_address)
                REG_CTRL: avs_readdata <= ctrl;
                REG_COLUMN: avs_readdata <= {19'h0_0000, column};
                REG_ROW: avs_readdata <= {13'h0000, row};
                REG_STATUS: avs_readdata <= {id_hi, last_byte, 15'h0000, busy};
                default: avs_readdata <= id_lo;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= 32'h0000_0000;
            column <= '0;
            row <= '0;
        end else if (avs_write && !avs_waitrequest) begin
            unique case (avs_address)
                REG_CTRL: ctrl <= avs_writedata;
                REG_COLUMN: column <= avs_writedata[COL_W-1:0];
                REG_ROW: row <= avs_writedata[PAGE_W+BLOCK_W-1:0];
                default: ;
            endcase
        end else if (state == NAH_DONE) begin
            ctrl[CTRL_GO] <= 1'b0;
        end
    end

    // =====================================================
    // pin sequencer; each step is a strobe low then high phase
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= NAH_IDLE;
            busy <= 1'b0;
            phase <= 3'd0;
            addr_idx <= 3'd0;
            rd_count <= 8'h00;
            timer <= 32'h0000_0000;
            after_id <= 1'b0;
            io_out <= 8'h00;
            io_oe <= 1'b0;
            cle <= 1'b0;
            ale <= 1'b0;
            we_n <= 1'b1;
            re_n <= 1'b1;
            ce_n <= 2'b11;
            last_byte <= 8'h00;
            id_lo <= 32'h0000_0000;
            id_hi <= 8'h00;
        end else begin
            unique case (state)
                NAH_IDLE: begin
                    if (ctrl[CTRL_GO] && !avs_write) begin
                        busy <= 1'b1;
                        ce_n <= ctrl[CTRL_CE_SEL] ? 2'b01 : 2'b10;
                        phase <= 3'd0;
                        addr_idx <= 3'd0;
                        rd_count <= 8'h00;
                        state <= NAH_CMD;
                    end
                end
                NAH_CMD: begin
                    phase <= phase + 3'd1;
                    if (phase == 3'd0) begin
                        cle <= 1'b1;
                        io_oe <= 1'b1;
                        we_n <= 1'b0;
                        unique case (op)
                            NAH_OP_ID: io_out <= CMD_READ_ID;
                            NAH_OP_PARAM: io_out <= CMD_PARAM_PAGE;
                            NAH_OP_STATUS: io_out <= after_id ? CMD_DUMMY_READ : CMD_STATUS;
                            default: io_out <= CMD_DUMMY_READ;
                        endcase
                    end else if (phase == 3'(STROBE_CYC)) begin
                        we_n <= 1'b1;
                    end else if (phase == 3'(STROBE_CYC + 1)) begin
                        cle <= 1'b0;
                        phase <= 3'd0;
                        if (op == NAH_OP_STATUS && after_id) begin
                            after_id <= 1'b0;
                        end else if (op == NAH_OP_STATUS) begin
                            io_oe <= 1'b0;
                            state <= NAH_READ;
                        end else begin
                            after_id <= (op == NAH_OP_ID);
                            state <= NAH_ADDR;
                        end
                    end
                end
                NAH_ADDR: begin
                    phase <= phase + 3'd1;
                    if (phase == 3'd0) begin
                        ale <= 1'b1;
                        io_out <= addr_byte;
                        we_n <= 1'b0;
                    end else if (phase == 3'(STROBE_CYC)) begin
                        we_n <= 1'b1;
                    end else if (phase == 3'(STROBE_CYC + 1)) begin
                        phase <= 3'd0;
                        if (op == NAH_OP_ADDR && addr_idx != 3'(ADDR_CYCLES - 1)) begin
                            addr_idx <= addr_idx + 3'd1;
                        end else begin
                            ale <= 1'b0;
                            io_oe <= 1'b0;
                            timer <= 32'h0000_0000;
                            state <= (op == NAH_OP_PARAM) ? NAH_WAIT
                                : (op == NAH_OP_ID) ? NAH_READ : NAH_DONE;
                        end
                    end
                end
                NAH_WAIT: begin
                    // busy may take a few cycles to appear, so ready counts only after a settle
                    timer <= timer + 32'd1;
                    if (ctrl[CTRL_USE_POLL]) begin
                        state <= NAH_POLL_CMD;
                        phase <= 3'd0;
                    end else if (timer >= 32'(LOAD_CYC)
                        || (timer > 32'(RB_SETTLE_CYC) && rb_level)) begin
                        state <= NAH_READ;
                    end
                end
                NAH_POLL_CMD, NAH_REARM: begin
                    phase <= phase + 3'd1;
                    if (phase == 3'd0) begin
                        cle <= 1'b1;
                        io_oe <= 1'b1;
                        io_out <= (state == NAH_REARM) ? CMD_DUMMY_READ : CMD_STATUS;
                        we_n <= 1'b0;
                    end else if (phase == 3'(STROBE_CYC)) begin
                        we_n <= 1'b1;
                    end else if (phase == 3'(STROBE_CYC + 1)) begin
                        cle <= 1'b0;
                        io_oe <= 1'b0;
                        phase <= 3'd0;
                        rd_count <= 8'h00;
                        state <= (state == NAH_REARM) ? NAH_READ : NAH_POLL_RD;
                    end
                end
                NAH_POLL_RD, NAH_READ: begin
                    phase <= phase + 3'd1;
                    if (state == NAH_READ && rd_count == ctrl[CTRL_COUNT_LO +: 8]) begin
                        state <= NAH_DONE;
                    end else if (phase == 3'd0) begin
                        re_n <= 1'b0;
                    end else if (phase == 3'(STROBE_CYC)) begin
                        re_n <= 1'b1;
                        last_byte <= io_level;
                        if (state == NAH_POLL_RD) begin
                            if ((io_level & STATUS_READY_BIT) != 8'h00) begin
                                state <= NAH_REARM;
                                phase <= 3'd0;
                            end
                        end else if (op == NAH_OP_ID && rd_count < 8'd4) begin
                            id_lo <= {io_level, id_lo[31:8]};
                        end else if (op == NAH_OP_ID && rd_count == 8'd4) begin
                            id_hi <= io_level;
                        end
                        rd_count <= rd_count + 8'd1;
                    end else if (phase == 3'(STROBE_CYC + 1)) begin
                        phase <= 3'd0;
                    end
                end
                NAH_DONE: begin
                    ce_n <= 2'b11;
                    busy <= 1'b0;
                    state <= NAH_IDLE;
                end
                default: state <= NAH_IDLE;
            endcase
        end
    end
endmodule

// [verification/nah_host_asserts.sv]
// nah_host_asserts: pin-level checks on the nand host controller
// assumes bound into nah_host; one clock, synchronous active high reset
`timescale 1ns/1ps
module nah_host_asserts
    import nah_pkg::*;
#(
    parameter int LOAD_CYC = ARRAY_LOAD_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] io_in,
    input wire logic [7:0] io_out,
    input wire logic io_oe,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic [1:0] ce_n,
    input wire logic ready_busy_n
);
    // =====================================================
    // last command byte the device has latched
    logic [7:0] last_cmd;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            last_cmd <= 8'h00;
        end else if ($rose(we_n) && cle) begin
            last_cmd <= io_out;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // =====================================================
    // pin relations
    AST_LATCH_EXCL: assert property (!(cle && ale))
        else $error("cle and ale high together");
    AST_WE_WIDTH: assert property ($fell(we_n) |-> (!we_n) [*5] ##1 we_n)
        else $error("write strobe width wrong");
    AST_WE_HOLD: assert property (!we_n && !$past(we_n)
        |-> $stable(io_out) && io_oe && $stable(cle)) else $error("bus moved under write strobe");
    AST_RE_WIDTH: assert property ($fell(re_n) |-> (!re_n) [*5] ##1 re_n)
        else $error("read strobe width wrong");
    AST_RE_FREE: assert property (!re_n |-> !io_oe && !cle && !ale)
        else $error("host drives bus during read");
    AST_CE_ONE: assert property (!we_n || !re_n |-> $onehot(~ce_n) && $stable(ce_n))
        else $error("die select not held");
    AST_ID_ADDR: assert property ($rose(we_n) && cle && io_out == CMD_READ_ID
        |-> ##[1:40] ($rose(we_n) && ale && io_out == ADDR_ZERO)) else $error("id address missing");
    AST_PARAM_ADDR: assert property ($rose(we_n) && cle && io_out == CMD_PARAM_PAGE
        |-> ##[1:40] ($rose(we_n) && ale && io_out == ADDR_ZERO)) else $error("param address missing");
    AST_STATUS_DUMMY: assert property ($rose(we_n) && cle && io_out == CMD_STATUS
        |-> last_cmd != CMD_READ_ID) else $error("status right after id");
    AST_PARAM_READY: assert property ($fell(re_n) && last_cmd == CMD_PARAM_PAGE |-> ready_busy_n)
        else $error("param read while busy");
endmodule
bind nah_host nah_host_asserts #(.LOAD_CYC(LOAD_CYC)) u_asserts (.clk_sys, .reset, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .io_in, .io_out,
    .io_oe, .cle, .ale, .we_n, .re_n, .ce_n, .ready_busy_n);

// [verification/nah_nand_model.sv]
// nah_nand_model: behavioural dual-die nand, id, parameter page and status only
// assumes pins straight from nah_host; busy time counted on clk_sys
`timescale 1ns/1ps
module nah_nand_model
    import nah_pkg::*;
#(
    parameter logic [7:0] MAKER = 8'h5a, // arbitrary value
    parameter logic [7:0] DEVICE = 8'ha7 // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic [7:0] io_out,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic [1:0] ce_n,
    input wire logic [31:0] busy_len,
    output logic [7:0] io_in,
    output logic ready_busy_n
);
    // =====================================================
    // fixed content
    localparam logic [7:0] ID_B [5] = '{MAKER, DEVICE, 8'h01, 8'h05, 8'h04};
    localparam logic [7:0] PAGE [8] = '{8'h4f, 8'h4e, 8'h46, 8'h49, 8'h02, 8'h00, 8'h18, 8'h00};
    logic [7:0] cmd_q [$];
    logic [7:0] addr_q [$];
    logic [7:0] last = 8'h00;
    logic [7:0] rd = 8'h00;
    logic [1:0] ce_seen = 2'b11;
    logic src_param = 1'b0;
    logic stat = 1'b0;
    int ptr = 0;
    int busy = 0;
    wire sel = ce_n != 2'b11;
    // =====================================================
    // latching on the write strobe rise
    always @(posedge we_n) begin
        if (sel && cle) begin
            ce_seen = ce_n;
            cmd_q.push_back(io_out);
            // status straight after id is not honoured, as on the real part
            stat = io_out == CMD_STATUS && last != CMD_READ_ID;
            if (io_out != CMD_DUMMY_READ && !stat) begin
                src_param = io_out == CMD_PARAM_PAGE;
                ptr = 0;
            end
            last = io_out;
        end else if (sel && ale) begin
            addr_q.push_back(io_out);
            if (last == CMD_PARAM_PAGE) busy = busy_len;
        end
    end
    always @(negedge re_n) begin
        if (sel && stat) begin
            rd = busy == 0 ? STATUS_READY_BIT : 8'h00;
        end else if (sel) begin
            rd = src_param ? (ptr < 8 ? PAGE[ptr] : 8'h00) : ID_B[ptr % 5];
            ptr++;
        end
    end
    always @(posedge clk_sys) if (busy > 0) busy--;
    // released bus shows the inverse so a stale value never passes
    assign io_in = (!re_n && sel) ? rd : ~rd;
    assign ready_busy_n = busy == 0;
endmodule

// [verification/nah_host_test.sv]
// nah_host_test: self-checking bench for the nand host controller
// assumes nah_nand_model on the pins and avalon-mm register access
`timescale 1ns/1ps
module nah_host_test
    import nah_pkg::*;
;
    logic clk_sys, reset, avs_read, avs_write, avs_waitrequest, io_oe, cle, ale, we_n, re_n;
    logic ready_busy_n, die;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed, rd, v, busy_len;
    logic [7:0] io_in, io_out;
    logic [1:0] ce_n;
    int failures, n_compared, k;
    logic [7:0] exp_id [5];
    // =====================================================
    // design and far side
    nah_host #(.LOAD_CYC(50)) uut (.clk_sys, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .io_in, .io_out, .io_oe, .cle, .ale,
        .we_n, .re_n, .ce_n, .ready_busy_n);
    nah_nand_model m (.clk_sys, .io_out, .cle, .ale, .we_n, .re_n, .ce_n, .busy_len, .io_in,
        .ready_busy_n);
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // =====================================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // one avalon transfer; holds until waitrequest is seen low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 100; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i == 100) begin
            failures++;
            summarize();
        end
    endtask
    task automatic op(input nah_op_t o, input logic [7:0] n, input logic poll);
        int i;
        m.cmd_q.delete();
        m.addr_q.delete();
        av(1'b1, REG_CTRL, {16'h0000, n, 2'b00, poll, die, 1'b0, o, 1'b1});
        for (i = 0; i < 3000; i++) begin
            av(1'b0, REG_STATUS, 32'h0000_0000);
            if (rd[0] === 1'b0) break;
        end
        if (i == 3000) begin
            failures++;
            summarize();
        end
    endtask
    // =====================================================
    // main sequence
    initial begin
        seed = 32'h0000_001e;
        {reset, avs_read, avs_write, die} = 4'hf;
        {avs_read, avs_write} = 2'b00;
        avs_address = 4'h0;
        avs_writedata = 32'h0000_0000;
        busy_len = 32'h0000_0014;
        exp_id = '{8'h5a, 8'ha7, {4'h0, 2'b00, 2'b01}, {4'h0, 2'b01, 2'b01}, {4'h0, 2'b01, 2'b00}};
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        for (k = 0; k < 2; k++) begin
            v = xs();
            die = v[0];
            op(NAH_OP_ID, 8'h05, 1'b0);
            chk("id cmd", {24'h0, CMD_READ_ID}, {24'h0, m.cmd_q[0]});
            chk("id addr", {24'h0, ADDR_ZERO}, {24'h0, m.addr_q[0]});
            chk("die sel", {30'h0, ~(2'b01 << die)}, {30'h0, m.ce_seen});
            av(1'b1, 4'h6, xs());
            av(1'b0, 4'h2, 32'h0000_0000);
            chk("id word", {exp_id[3], exp_id[2], exp_id[1], exp_id[0]}, rd);
            av(1'b0, REG_STATUS, 32'h0000_0000);
            chk("id fifth", {exp_id[4], exp_id[4], 16'h0}, {rd[31:16], 16'h0});
            op(NAH_OP_STATUS, 8'h01, 1'b0);
            chk("status dummy", {24'h0, CMD_DUMMY_READ}, {24'h0, m.cmd_q[0]});
            chk("status cmd", {24'h0, CMD_STATUS}, {24'h0, m.cmd_q[1]});
            chk("status byte", {24'h0, STATUS_READY_BIT}, {24'h0, rd[23:16]});
        end
        for (k = 0; k < 4; k++) begin
            v = k == 0 ? 32'h7fff_ffff : xs();
            av(1'b1, REG_COLUMN, {19'h0_0000, v[12:0]});
            av(1'b1, REG_ROW, {13'h0000, v[30:12]});
            op(NAH_OP_ADDR, 8'h00, 1'b0);
            chk("addr count", 32'h0000_0005, m.addr_q.size());
            chk("col one", {24'h0, v[7:0]}, {24'h0, m.addr_q[0]});
            chk("col two", {24'h0, 4'h0, v[11:8]}, {24'h0, m.addr_q[1]});
            chk("row one", {24'h0, v[19:18], v[17:12]}, {24'h0, m.addr_q[2]});
            chk("row two", {24'h0, v[27:20]}, {24'h0, m.addr_q[3]});
            chk("row three", {24'h0, 5'h00, v[30:28]}, {24'h0, m.addr_q[4]});
        end
        for (k = 0; k < 2; k++) begin
            busy_len = 32'h0000_0014 + 32'(20 * k);
            op(NAH_OP_PARAM, 8'h05, k[0]);
            chk("param cmd", {24'h0, CMD_PARAM_PAGE}, {24'h0, m.cmd_q[0]});
            chk("param addr", {24'h0, ADDR_ZERO}, {24'h0, m.addr_q[0]});
            chk("param rev", 32'h0000_0002, {24'h0, rd[23:16]});
        end
        summarize();
    end
endmodule
